// >>> rtl/gpd_pkg.sv
// Purpose: Shared constants for the GPIO PWM input decoder block.
// Assumes: 32-bit AHB-Lite register access, one word per register.
// Notes:   Level codes are shared by the decoder and the readback registers.
package gpd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [31:0] OFS_MAIN_CFG = 32'h0000_0000;
  localparam logic [31:0] OFS_AUX_CFG  = 32'h0000_0004;
  localparam logic [31:0] OFS_READBACK = 32'h0000_0008;

  // Main configuration fields: format bits and two-bit timebase fields.
  localparam int MAIN_FMT_LSB = 0;
  localparam int MAIN_TB_LSB  = 8;

  // Auxiliary configuration fields.
  localparam int AUX_DIR_LSB  = 0;
  localparam int AUX_FMT_LSB  = 4;
  localparam int AUX_TB_LSB   = 8;
  localparam int AUX_VAL_LSB  = 16;

  // Readback fields.
  localparam int RB_MAIN_LSB  = 0;
  localparam int RB_AUX_LSB   = 16;

  // Reset values.
  localparam logic [31:0] MAIN_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] AUX_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Timebase prescaler: a tick fires when the masked prescaler bits are zero.
  localparam int          PRE_W   = 10;
  localparam logic [9:0]  TB_MASK0 = 10'h000;
  localparam logic [9:0]  TB_MASK1 = 10'h00f;
  localparam logic [9:0]  TB_MASK2 = 10'h07f;
  localparam logic [9:0]  TB_MASK3 = 10'h3ff;

  // Decoded level codes in a two-bit readback field.
  localparam logic [1:0] LVL_STUCK_LO = 2'h0;
  localparam logic [1:0] LVL_STUCK_HI = 2'h1;
  localparam logic [1:0] LVL_PWM_LO   = 2'h2;
  localparam logic [1:0] LVL_PWM_HI   = 2'h3;

  // Phase counter width in bits; the counters count timebase ticks.
  localparam int CNT_W = 8;

endpackage

// >>> rtl/gpd_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs.
// Assumes: Inputs change independently of clk_sys.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module gpd_sync #(
  parameter int W = 1
) (
  input  logic         clk_sys,
  input  logic         srst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Two flip-flops in series, cleared by reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// >>> rtl/gpd_pwm_decoder.sv
// Purpose: Decodes one PWM input into a two-bit level code.
// Assumes: pin is already synchronised; tick is a one-cycle timebase pulse.
// Notes:   A period is low phase then high phase; the result updates at its end.
`timescale 1ns/100ps
module gpd_pwm_decoder #(
  parameter int CW = gpd_pkg::CNT_W
) (
  input  logic       clk_sys,
  input  logic       srst,
  input  logic       pin,
  input  logic       tick,
  output logic [1:0] level
);

  logic          prev_r;
  logic [CW-1:0] lo_cnt_r;
  logic [CW-1:0] hi_cnt_r;
  logic [CW-1:0] lo_lat_r;
  logic [1:0]    level_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Edge and saturation decode.
  wire rise   = pin & ~prev_r;
  wire fall   = ~pin & prev_r;
  wire lo_sat = &lo_cnt_r;
  wire hi_sat = &hi_cnt_r;

  // Phase counters count timebase ticks; a rising edge closes the low phase.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_r   <= 1'b0;
      lo_cnt_r <= '0;
      hi_cnt_r <= '0;
      lo_lat_r <= '0;
    end else begin
      prev_r <= pin;
      if (rise || fall) begin
        lo_cnt_r <= '0;
        hi_cnt_r <= '0;
      end else if (tick && !pin && !lo_sat) begin
        lo_cnt_r <= lo_cnt_r + 1'b1;
      end else if (tick && pin && !hi_sat) begin
        hi_cnt_r <= hi_cnt_r + 1'b1;
      end
      if (rise) begin
        lo_lat_r <= lo_cnt_r;
      end
    end
  end

  // Level resolves at each period end, or on a line stuck for a full count.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level_r <= gpd_pkg::LVL_STUCK_LO;
    end else if (fall) begin
      level_r <= (hi_cnt_r > lo_lat_r) ? gpd_pkg::LVL_PWM_HI : gpd_pkg::LVL_PWM_LO;
    end else if (!pin && lo_sat) begin
      level_r <= gpd_pkg::LVL_STUCK_LO;
    end else if (pin && hi_sat) begin
      level_r <= gpd_pkg::LVL_STUCK_HI;
    end
  end

  assign level = level_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the decoder.
  chk_period_result: assert property (@(posedge clk_sys) disable iff (srst)
    fall |=> level_r == (($past(hi_cnt_r) > $past(lo_lat_r)) ? gpd_pkg::LVL_PWM_HI
                                                             : gpd_pkg::LVL_PWM_LO))
    else $error("Decoded level does not match the finished period.");

  chk_low_latch_edge: assert property (@(posedge clk_sys) disable iff (srst)
    !rise |=> lo_lat_r == $past(lo_lat_r))
    else $error("Low phase length latched outside a rising edge.");

  chk_count_timebase: assert property (@(posedge clk_sys) disable iff (srst)
    (!tick && !rise && !fall) |=> (lo_cnt_r == $past(lo_cnt_r)) && (hi_cnt_r == $past(hi_cnt_r)))
    else $error("Phase counter moved without a timebase tick.");

  chk_stuck_low: assert property (@(posedge clk_sys) disable iff (srst)
    (!pin && lo_sat && !fall) |=> level_r == gpd_pkg::LVL_STUCK_LO)
    else $error("Line held low did not report the stuck low code.");

endmodule

// >>> rtl/gpd_top.sv
// Purpose: GPIO input decoding for five main pins and four auxiliary pins.
// Assumes: AHB-Lite single word transfers, one slave; pins are asynchronous.
// Notes:   Zero wait state slave; unmapped addresses read zero and ignore writes.
`timescale 1ns/100ps
module gpd_top #(
  parameter int N_MAIN = 5,
  parameter int N_AUX  = 4
) (
  input  logic              clk_sys,
  input  logic              srst,
  input  logic              hsel,
  input  logic [31:0]       haddr,
  input  logic [1:0]        htrans,
  input  logic              hwrite,
  input  logic [2:0]        hsize,
  input  logic [31:0]       hwdata,
  input  logic              hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  logic [N_MAIN-1:0] main_pin_in,
  input  logic [N_AUX-1:0]  aux_pin_in,
  output logic [N_AUX-1:0]  aux_pin_out,
  output logic [N_AUX-1:0]  aux_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Timebase tick select for a two-bit timebase field.
  function automatic logic tb_tick(input logic [gpd_pkg::PRE_W-1:0] cnt,
                                   input logic [1:0] tb);
    logic [gpd_pkg::PRE_W-1:0] mask;
    mask = gpd_pkg::TB_MASK0;
    case (tb)
      2'h0:    mask = gpd_pkg::TB_MASK0;
      2'h1:    mask = gpd_pkg::TB_MASK1;
      2'h2:    mask = gpd_pkg::TB_MASK2;
      default: mask = gpd_pkg::TB_MASK3;
    endcase
    return (cnt & mask) == '0;
  endfunction

  logic [31:0]               main_cfg_r;
  logic [31:0]               aux_cfg_r;
  logic [gpd_pkg::PRE_W-1:0] pre_r;
  logic                      wr_pend_r;
  logic [31:0]               wr_addr_r;
  logic [2*N_MAIN-1:0]       main_rb_r;
  logic [2*N_AUX-1:0]        aux_rb_r;
  logic [N_MAIN-1:0]         main_sync;
  logic [N_AUX-1:0]          aux_sync;
  logic [2*N_MAIN-1:0]       main_dec;
  logic [2*N_AUX-1:0]        aux_dec;
  logic [2*N_MAIN-1:0]       main_rb_nxt;
  logic [2*N_AUX-1:0]        aux_rb_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration fields.
  wire [N_MAIN-1:0]   main_fmt   = main_cfg_r[gpd_pkg::MAIN_FMT_LSB +: N_MAIN];
  wire [2*N_MAIN-1:0] main_tb    = main_cfg_r[gpd_pkg::MAIN_TB_LSB +: 2*N_MAIN];
  wire [N_AUX-1:0]    aux_dir    = aux_cfg_r[gpd_pkg::AUX_DIR_LSB +: N_AUX];
  wire [N_AUX-1:0]    aux_fmt    = aux_cfg_r[gpd_pkg::AUX_FMT_LSB +: N_AUX];
  wire [2*N_AUX-1:0]  aux_tb     = aux_cfg_r[gpd_pkg::AUX_TB_LSB +: 2*N_AUX];
  wire [N_AUX-1:0]    aux_value  = aux_cfg_r[gpd_pkg::AUX_VAL_LSB +: N_AUX];

  // Bus decode.
  wire        addr_ph   = hsel & htrans[1] & hready;
  wire [31:0] word_addr = {haddr[31:2], 2'b00};
  wire        wr_main   = wr_pend_r & (wr_addr_r == gpd_pkg::OFS_MAIN_CFG);
  wire        wr_aux    = wr_pend_r & (wr_addr_r == gpd_pkg::OFS_AUX_CFG);

  // Read word selection; unmapped words read zero.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    case (word_addr)
      gpd_pkg::OFS_MAIN_CFG: rd_word = main_cfg_r;
      gpd_pkg::OFS_AUX_CFG:  rd_word = aux_cfg_r;
      gpd_pkg::OFS_READBACK: begin
        rd_word[gpd_pkg::RB_MAIN_LSB +: 2*N_MAIN] = main_rb_r;
        rd_word[gpd_pkg::RB_AUX_LSB +: 2*N_AUX]   = aux_rb_r;
      end
      default:               rd_word = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: read data captured in the address phase, write in the data phase.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= gpd_pkg::RDATA_RST;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= addr_ph & hwrite;
      if (addr_ph) begin
        wr_addr_r <= word_addr;
      end
      if (addr_ph && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      main_cfg_r <= gpd_pkg::MAIN_CFG_RST;
      aux_cfg_r  <= gpd_pkg::AUX_CFG_RST;
    end else begin
      if (wr_main) begin
        main_cfg_r <= hwdata;
      end
      if (wr_aux) begin
        aux_cfg_r <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running timebase prescaler.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Pin synchronisers.
  gpd_sync #(.W(N_MAIN)) u_main_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (main_pin_in),
    .q       (main_sync)
  );

  gpd_sync #(.W(N_AUX)) u_aux_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       (aux_pin_in),
    .q       (aux_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // One decoder per pin, each ticking on its own timebase.
  genvar gi;
  generate
    for (gi = 0; gi < N_MAIN; gi++) begin : g_main
      gpd_pwm_decoder u_dec (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pin     (main_sync[gi]),
        .tick    (tb_tick(pre_r, main_tb[2*gi +: 2])),
        .level   (main_dec[2*gi +: 2])
      );
      assign main_rb_nxt[2*gi +: 2] = main_fmt[gi] ? main_dec[2*gi +: 2]
                                                   : {1'b0, main_sync[gi]};
    end
    for (gi = 0; gi < N_AUX; gi++) begin : g_aux
      gpd_pwm_decoder u_dec (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pin     (aux_sync[gi]),
        .tick    (tb_tick(pre_r, aux_tb[2*gi +: 2])),
        .level   (aux_dec[2*gi +: 2])
      );
      assign aux_rb_nxt[2*gi +: 2] = aux_fmt[gi] ? aux_dec[2*gi +: 2]
                                                 : {1'b0, aux_sync[gi]};
    end
  endgenerate

  // Readback registers sample every pin on every clock, whatever its direction.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      main_rb_r <= '0;
      aux_rb_r  <= '0;
    end else begin
      main_rb_r <= main_rb_nxt;
      aux_rb_r  <= aux_rb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Push-pull static outputs; the format bit never reaches the output path.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aux_pin_out <= '0;
      aux_pin_oe  <= '0;
    end else begin
      aux_pin_out <= aux_value;
      aux_pin_oe  <= aux_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on configuration, readback and outputs.
  chk_main_static_rb: assert property (@(posedge clk_sys) disable iff (srst)
    (!main_fmt[0] && $past(!main_fmt[0])) |-> main_rb_r[1:0] == {1'b0, $past(main_sync[0])})
    else $error("Static main pin readback does not follow the pin.");

  chk_aux_static_rb: assert property (@(posedge clk_sys) disable iff (srst)
    (aux_dir[0] && !aux_fmt[0] && $past(!aux_fmt[0]))
      |-> aux_rb_r[1:0] == {1'b0, $past(aux_sync[0])})
    else $error("Output pin readback does not follow the pin.");

  chk_dir_enable: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(aux_dir[0]) |=> aux_pin_oe[0] ##1 (aux_pin_oe[0] == aux_dir[0]))
    else $error("Direction bit did not enable the driver.");

  chk_static_out: assert property (@(posedge clk_sys) disable iff (srst)
    (aux_fmt[2] && aux_dir[2] && $past(aux_dir[2])) |-> aux_pin_out[2] == $past(aux_value[2]))
    else $error("Output in PWM format did not drive the static value.");

  chk_push_pull: assert property (@(posedge clk_sys) disable iff (srst)
    ($changed(aux_pin_out) && !$changed(aux_pin_oe)) |=> aux_pin_oe == $past(aux_pin_oe, 2))
    else $error("Driver enable followed output data.");

  chk_reset_inputs: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> (aux_pin_oe == '0) && (aux_dir == '0))
    else $error("Auxiliary pins not inputs at reset release.");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the bus slave, which answers every transfer with no wait state.
  chk_ready_high: assert property (@(posedge clk_sys) disable iff (srst)
    hreadyout)
    else $error("Slave inserted a wait state.");

  // Every response is OKAY; the block has no error condition of its own.
  chk_resp_okay: assert property (@(posedge clk_sys) disable iff (srst)
    !hresp)
    else $error("Slave answered with an error response.");

  // Read data is taken at the edge that takes the address, so the master finds it
  // standing through the whole data phase that follows.
  chk_read_capture: assert property (@(posedge clk_sys) disable iff (srst)
    (addr_ph && !hwrite) |=> hrdata == $past(rd_word))
    else $error("Read data does not hold the addressed word.");

  // Read data must hold between reads, since the master may sample it late.
  chk_read_hold: assert property (@(posedge clk_sys) disable iff (srst)
    !(addr_ph && !hwrite) |=> hrdata == $past(hrdata))
    else $error("Read data changed without a read.");

  // A write lands at the end of its data phase, with the data then on hwdata.
  chk_write_main: assert property (@(posedge clk_sys) disable iff (srst)
    wr_main |=> main_cfg_r == $past(hwdata))
    else $error("Main configuration write did not land.");

  chk_write_aux: assert property (@(posedge clk_sys) disable iff (srst)
    wr_aux |=> aux_cfg_r == $past(hwdata))
    else $error("Auxiliary configuration write did not land.");

  // Configuration must never move without a write; a stray update would flip pins.
  chk_cfg_stable: assert property (@(posedge clk_sys) disable iff (srst)
    (!wr_main && !wr_aux)
      |=> (main_cfg_r == $past(main_cfg_r)) && (aux_cfg_r == $past(aux_cfg_r)))
    else $error("Configuration changed without a write.");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the timebase, which every decoder shares.
  chk_prescale_step: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(srst) |-> pre_r == $past(pre_r) + 1'b1)
    else $error("Timebase prescaler skipped a step.");

  // The slowest timebase must tick exactly once in every wrap of the prescaler.
  chk_slow_tick: assert property (@(posedge clk_sys) disable iff (srst)
    tb_tick(pre_r, 2'h3) |-> pre_r == '0)
    else $error("Slowest timebase ticked off its wrap point.");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on readback in PWM format: the field shows the decoder one cycle late.
  chk_main_pwm_rb: assert property (@(posedge clk_sys) disable iff (srst)
    (main_fmt[0] && $past(main_fmt[0])) |-> main_rb_r[1:0] == $past(main_dec[1:0]))
    else $error("Main pin readback does not show the decoder.");

  chk_aux_pwm_rb: assert property (@(posedge clk_sys) disable iff (srst)
    (aux_fmt[3] && $past(aux_fmt[3])) |-> aux_rb_r[7:6] == $past(aux_dec[7:6]))
    else $error("Auxiliary pin readback does not show the decoder.");

  // A static auxiliary pin must follow the wire, whatever its direction.
  chk_aux_in_rb: assert property (@(posedge clk_sys) disable iff (srst)
    (!aux_fmt[1] && $past(!aux_fmt[1])) |-> aux_rb_r[3:2] == {1'b0, $past(aux_sync[1])})
    else $error("Static auxiliary readback does not follow the pin.");

  // Readback comes out of reset cleared, before any pin has been sampled.
  chk_rb_reset: assert property (@(posedge clk_sys) disable iff (srst)
    $past(srst) |-> (main_rb_r == '0) && (aux_rb_r == '0))
    else $error("Readback not cleared at reset release.");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the output path: both enable and level follow configuration.
  chk_oe_follow: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(srst) |-> aux_pin_oe == $past(aux_dir))
    else $error("Driver enable does not follow the direction bits.");

  // The level follows its value bit alone; no pulse train ever reaches a pin.
  chk_out_follow: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(srst) |-> aux_pin_out == $past(aux_value))
    else $error("Output level does not follow the value bits.");

  // An output level only moves two cycles after a write to the auxiliary word.
  chk_out_no_pwm: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(aux_pin_out) |-> $past(wr_aux, 2))
    else $error("Output level moved without a configuration write.");

  // A pin set to input must see its own driver off on the very next cycle.
  chk_input_off: assert property (@(posedge clk_sys) disable iff (srst)
    !aux_dir[3] |=> !aux_pin_oe[3])
    else $error("Driver stayed on for an input pin.");

  // Main pins in static format report only the two static codes.
  chk_main_static_code: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(main_fmt[4]) |-> !main_rb_r[9])
    else $error("Static main pin reported a PWM code.");

  // Auxiliary pins in static format likewise.
  chk_aux_static_code: assert property (@(posedge clk_sys) disable iff (srst)
    !$past(aux_fmt[2]) |-> !aux_rb_r[5])
    else $error("Static auxiliary pin reported a PWM code.");

  // Main pin 1 ticks on its own field, not on the field of pin 0.
  chk_main_tb_own: assert property (@(posedge clk_sys) disable iff (srst)
    (main_tb[3:2] == 2'h0) |-> g_main[1].u_dec.tick)
    else $error("Main pin decoder missed a tick on the fastest timebase.");

  // Auxiliary pin 0 on the fastest timebase sees a tick on every clock.
  chk_aux_tb_own: assert property (@(posedge clk_sys) disable iff (srst)
    (aux_tb[1:0] == 2'h0) |-> g_aux[0].u_dec.tick)
    else $error("Auxiliary pin decoder missed a tick on the fastest timebase.");

endmodule

// >>> bench/gpd_pin_src.sv
// Purpose: Pin source model driving static or PWM levels into the block.
// Assumes: One shared period counter serves every pin.
// Notes:   A new PWM level takes effect only at the start of a period.
`timescale 1ns/100ps
module gpd_pin_src #(
  parameter int N = 9
) (
  input  wire logic [N-1:0] pwm_en,
  input  wire logic         clk_sys,
  input  wire logic [N-1:0] lvl,
  input  wire logic [15:0]  t_short, // In clk_sys cycles, not decoder ticks.
  input  wire logic [15:0]  t_long,
  output logic      [N-1:0] pin
);
  logic [15:0]  cnt = 16'h0000;
  logic [N-1:0] cur = {N{1'b0}};

  ////////////////////////////////////////////////////////////////////////////////
  // Period counter; a PWM level change waits for the next period.
  always_ff @(posedge clk_sys) begin
    if (int'(cnt) >= int'(t_short) + int'(t_long) - 1) begin
      cnt <= 16'h0000;
      cur <= lvl;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  // Low phase first, then high; a high level has the longer high phase.
  for (genvar i = 0; i < N; i++) begin : g_pin
    assign pin[i] = pwm_en[i] ? (cnt >= (cur[i] ? t_short : t_long)) : lvl[i];
  end
endmodule

// >>> bench/tb.sv
// Purpose: Self-checking bench for the GPIO PWM input decoder.
// Assumes: Zero wait state bus slave; fast timebases for short runs.
// Notes:   Aux wire level is resolved here from drive and source.
`timescale 1ns/100ps
module tb;
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [8:0]  pwm_en  = 9'h000;
  logic [8:0]  lvl     = 9'h000;
  logic [15:0] t_short = 16'h0002;
  logic [15:0] t_long  = 16'h0006;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [8:0]  src;
  logic [3:0]  aux_pin_in;
  logic [3:0]  aux_pin_out;
  logic [3:0]  aux_pin_oe;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          compares  = 0;

  // Free running system clock.
  always #50 clk_sys = ~clk_sys;

  // The block's push-pull drive wins over the source on the aux wire.
  assign aux_pin_in = (aux_pin_oe & aux_pin_out) | (~aux_pin_oe & src[8:5]);

  gpd_top u_gpd_top (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .main_pin_in(src[4:0]),
    .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe));

  gpd_pin_src u_gpd_pin_src (.clk_sys(clk_sys), .pwm_en(pwm_en), .lvl(lvl),
    .t_short(t_short), .t_long(t_long), .pin(src));

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits for hready under a bounded count.
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask

  // Read after one idle cycle and compare.
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string name);
    @(posedge clk_sys);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp, name);
  endtask

  // Expected readback word from per-pin format and level.
  function automatic logic [31:0] rbx(input logic [8:0] pw, input logic [8:0] l);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 9; i++) begin
      r[(i < 5 ? 2 * i : 2 * i + 6) +: 2] = pw[i] ?
        (l[i] ? gpd_pkg::LVL_PWM_HI : gpd_pkg::LVL_PWM_LO) : {1'b0, l[i]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rd_chk(gpd_pkg::OFS_MAIN_CFG, gpd_pkg::MAIN_CFG_RST, "main_cfg");
    rd_chk(gpd_pkg::OFS_AUX_CFG, gpd_pkg::AUX_CFG_RST, "aux_cfg");
    chk({28'h0, aux_pin_oe}, 32'h0, "oe_reset");
    lvl <= 9'h0b6;
    repeat (6) @(posedge clk_sys);
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h000, 9'h0b6), "static");
    bus(gpd_pkg::OFS_MAIN_CFG, 1'b1, 32'h0000_001f);
    bus(gpd_pkg::OFS_AUX_CFG, 1'b1, 32'h0000_00f0);
    pwm_en <= 9'h1ff;
    lvl    <= 9'h169;
    repeat (40) @(posedge clk_sys);
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h1ff, 9'h169), "pwm_tb0");
    lvl <= 9'h096;
    repeat (30) @(posedge clk_sys);
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h1ff, 9'h096), "pwm_change");
    // Static high in PWM format; main pin 0 runs on the slower timebase.
    bus(gpd_pkg::OFS_MAIN_CFG, 1'b1, 32'h0000_011f);
    pwm_en <= 9'h000;
    lvl    <= 9'h1ff;
    repeat (300) @(posedge clk_sys);
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h001, 9'h1fe), "stuck_tb0");
    repeat (4200) @(posedge clk_sys);
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h000, 9'h1ff), "stuck_tb1");
    // Slow PWM on timebases one and two, mixed per pin.
    t_short <= 16'h0100;
    t_long  <= 16'h0300;
    bus(gpd_pkg::OFS_MAIN_CFG, 1'b1, 32'h0001_991f);
    bus(gpd_pkg::OFS_AUX_CFG, 1'b1, 32'h0000_99f0);
    pwm_en <= 9'h1ff;
    lvl    <= 9'h169;
    repeat (4400) @(posedge clk_sys);
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h1ff, 9'h169), "pwm_tb12");
    // Aux pins 0 and 2 driven, the others follow the source.
    pwm_en <= 9'h000;
    lvl    <= 9'h1e0;
    bus(gpd_pkg::OFS_MAIN_CFG, 1'b1, 32'h0);
    bus(gpd_pkg::OFS_AUX_CFG, 1'b1, 32'h0001_0005);
    repeat (3) @(posedge clk_sys);
    chk({28'h0, aux_pin_oe}, 32'h5, "oe");
    chk({28'h0, aux_pin_out & aux_pin_oe}, 32'h1, "out_hi");
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h000, 9'h160), "aux_rb");
    bus(gpd_pkg::OFS_AUX_CFG, 1'b1, 32'h0004_00f5);
    repeat (2) @(posedge clk_sys);
    repeat (40) begin
      @(posedge clk_sys);
      chk({28'h0, aux_pin_out & aux_pin_oe}, 32'h4, "out_static");
    end
    chk({28'h0, aux_pin_oe}, 32'h5, "push_pull");
    chk({28'h0, aux_pin_out}, 32'h4, "no_pwm_out");
    // Reset in mid-run returns the aux pins to inputs.
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    chk({28'h0, aux_pin_oe}, 32'h0, "oe_rst2");
    rd_chk(gpd_pkg::OFS_AUX_CFG, 32'h0, "aux_rst2");
    // Read-only readback and an unmapped address ignore writes.
    bus(gpd_pkg::OFS_READBACK, 1'b1, 32'hffff_ffff);
    rd_chk(gpd_pkg::OFS_READBACK, rbx(9'h000, 9'h1e0), "read_only");
    bus(32'h0000_000c, 1'b1, 32'hffff_ffff);
    rd_chk(32'h0000_000c, 32'h0, "unmapped");
    results();
  end
endmodule
